// ---- logic/cbfg_defs.svh ----
// Constants for the chopper blanking and fault guard block.
`ifndef CBFG_DEFS_SVH
`define CBFG_DEFS_SVH

// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define CBFG_ADDR_CTRL 12'h000
`define CBFG_ADDR_STATUS 12'h004
`define CBFG_ADDR_CNT 12'h008
`define CBFG_ADDR_COIL 12'h00C

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CBFG_CTRL_CLR_BIT 0
`define CBFG_CTRL_RESET 32'h0000_0000

// ------------------------------------------------------------
// Blanking times in ns and fault figures
// ------------------------------------------------------------
`define CBFG_BLANK_T0_NS 600
`define CBFG_BLANK_T1_NS 900
`define CBFG_BLANK_T2_NS 1200
`define CBFG_BLANK_T3_NS 1500
`define CBFG_CLK_PERIOD_NS 5
`define CBFG_ERR_LIMIT 2'd3
`define CBFG_LOCK_CYCLES 6'd63
`define CBFG_QUIET_CYCLES 7'd64
`define CBFG_ZERO_CURRENT 4'h0

`endif

// ---- logic/cbfg_pkg.sv ----
// Types shared by the chopper blanking and fault guard block.
package cbfg_pkg;
	// Per-bridge fault state.
	typedef enum logic [1:0] {CBFG_RUN, CBFG_CYCLE_OFF, CBFG_LOCKED} cbfg_state_type;
endpackage

// ---- logic/cbfg_bridge_if.sv ----
// Interface carrying one bridge's guard signals between modules.
`timescale 1ns/1ps
`default_nettype none
interface cbfg_bridge_if;
	logic cycle_start; // Chopper cycle start pulse.
	logic oc_event; // Qualified overcurrent event pulse.
	logic clear; // Flag and counter clear pulse.
	logic off; // Bridge forced off.
	logic flag; // Error flag.
	logic [1:0] count; // Error counter.
	modport guard (input cycle_start, oc_event, clear, output off, flag, count);
	modport ctrl (output cycle_start, oc_event, clear, input off, flag, count);
endinterface
`default_nettype wire

// ---- logic/cbfg_blank_timer.sv ----
// Blanking pulse generator started by each bridge switching event.
`timescale 1ns/1ps
`default_nettype none
`include "cbfg_defs.svh"
module cbfg_blank_timer import cbfg_pkg::*; #(
	parameter int CW = 9 // Counter width.
) (
	input wire logic pclk, // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic sw_event, // Switching event pulse.
	input wire logic [CW-1:0] length, // Blank length in cycles.
	output logic blank // Blanking pulse.
);
	logic [CW-1:0] cnt_r; // Remaining blank cycles.

	// ------------------------------------------------------------
	// Blank counter
	// ------------------------------------------------------------
	// A switching event restarts the window; it then counts down.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (sw_event) begin
			cnt_r <= length;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	// Blanking is active while counting or on the event itself.
	assign blank = sw_event || (cnt_r != '0);
endmodule
`default_nettype wire

// ---- logic/cbfg_fault_counter.sv ----
// Overcurrent error counter, lock-off and flag for one detector.
`timescale 1ns/1ps
`default_nettype none
`include "cbfg_defs.svh"
module cbfg_fault_counter import cbfg_pkg::*; (
	input wire logic pclk, // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	cbfg_bridge_if.guard br // Guard signals.
);
	cbfg_state_type state_r; // Fault state.
	logic [1:0] cnt_r; // Error count.
	logic [5:0] lock_r; // Lock cycles left.
	logic [6:0] quiet_r; // Cycles without overcurrent.
	logic flag_r; // Error flag.

	// ------------------------------------------------------------
	// Error counter
	// ------------------------------------------------------------
	// Counts events, saturates at the limit, clears after a quiet run.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (br.oc_event) begin
			if (cnt_r != `CBFG_ERR_LIMIT) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end else if (br.clear) begin
			cnt_r <= '0;
		end else if (br.cycle_start && quiet_r >= `CBFG_QUIET_CYCLES) begin
			cnt_r <= '0;
		end
	end

	// Quiet cycle counter, restarted by each overcurrent event.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_r <= '0;
		end else if (br.oc_event) begin
			quiet_r <= '0;
		end else if (br.cycle_start && quiet_r != 7'h7F) begin
			quiet_r <= quiet_r + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Off state machine and flag
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= CBFG_RUN;
			lock_r <= '0;
		end else begin
			case (state_r)
				CBFG_RUN: begin
					if (br.oc_event && cnt_r == `CBFG_ERR_LIMIT - 2'd1) begin
						state_r <= CBFG_LOCKED;
						lock_r <= `CBFG_LOCK_CYCLES;
					end else if (br.oc_event) begin
						state_r <= CBFG_CYCLE_OFF;
					end
				end
				CBFG_CYCLE_OFF: begin
					if (br.cycle_start) begin
						state_r <= CBFG_RUN;
					end
				end
				CBFG_LOCKED: begin
					if (br.clear) begin
						state_r <= CBFG_RUN;
					end else if (br.cycle_start) begin
						if (lock_r == 6'd1) begin
							state_r <= CBFG_RUN;
						end
						lock_r <= lock_r - 6'd1;
					end
				end
				default: begin
					state_r <= CBFG_RUN;
				end
			endcase
		end
	end

	// Error flag: a new lock wins over a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
		end else if (br.oc_event && cnt_r >= `CBFG_ERR_LIMIT - 2'd1) begin
			flag_r <= 1'b1;
		end else if (br.clear) begin
			flag_r <= 1'b0;
		end
	end

	assign br.off = (state_r != CBFG_RUN);
	assign br.flag = flag_r;
	assign br.count = cnt_r;
endmodule
`default_nettype wire

// ---- logic/cbfg_guard.sv ----
// Top of the chopper blanking and overcurrent/overtemperature guard.
// Summary of operation
// - Two straps pick one of four blank times.
// - Each switching event starts a blanking pulse.
// - Low-side overcurrent ends cycle, bridge off.
// - Each overcurrent adds one to counter, saturating at three.
// - Count three locks bridge 63 cycles, flag.
// - Over 63 quiet cycles clears the counter.
// - Counter per low-side bridge plus high side.
// - Detection ignored during own bridge blanking.
// - High-side overcurrent turns both bridges off.
// - High-side blanking is OR of both.
// - Flags clear on re-enable or zero command.
// - Clearing flag also ends pending lock.
// - Overtemperature turns all off, sets flag.
// - Disable input above threshold disables driver.
`timescale 1ns/1ps
`default_nettype none
`include "cbfg_defs.svh"
module cbfg_guard import cbfg_pkg::*; #(
	parameter int BW = 9 // Blank counter width.
) (
	input wire logic pclk, // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB write.
	input wire logic [11:0] paddr, // APB address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error.
	input wire logic blank_select_low, // Blank strap low bit.
	input wire logic blank_select_high, // Blank strap high bit.
	input wire logic driver_disable_input, // Disable comparator, high disables.
	input wire logic cycle_start, // Chopper oscillator cycle start pulse.
	input wire logic [1:0] sw_event, // Switching event per bridge.
	input wire logic [1:0] ls_over, // Low-side sense above limit per bridge.
	input wire logic hs_over, // High-side sense above limit.
	input wire logic overtemp, // Overtemperature comparator.
	input wire logic cmd_valid, // Current command pulse.
	input wire logic [3:0] coil_a_word, // Coil A current word.
	input wire logic [3:0] coil_b_word, // Coil B current word.
	output logic [1:0] bridge_off, // Bridge forced off per bridge.
	output logic [2:0] err_flags, // Error flags A, B, high side.
	output logic overtemp_flag // Overtemperature flag.
);
	logic [BW-1:0] blank_len_r; // Strap-derived blank length.
	logic [1:0] blank; // Blanking per bridge.
	logic hs_blank; // High-side blanking window.
	logic dis_d_r; // Delayed disable input.
	logic sw_clear_r; // Software clear pulse.
	logic clear; // Combined flag clear.
	logic [3:0] last_a_r; // Last coil A word.
	logic [3:0] last_b_r; // Last coil B word.
	cbfg_bridge_if fa(); // Bridge A guard.
	cbfg_bridge_if fb(); // Bridge B guard.
	cbfg_bridge_if fh(); // High-side guard.

	// Converts ns to whole cycles, rounded up.
	function automatic logic [BW-1:0] ns_to_cyc(input int ns);
		ns_to_cyc = BW'((ns + `CBFG_CLK_PERIOD_NS - 1) / `CBFG_CLK_PERIOD_NS);
	endfunction

	// ------------------------------------------------------------
	// Blank time selection
	// ------------------------------------------------------------
	// Straps are sampled every clock after reset release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_len_r <= '0;
		end else begin
			case ({blank_select_high, blank_select_low})
				2'b00: blank_len_r <= ns_to_cyc(`CBFG_BLANK_T0_NS);
				2'b01: blank_len_r <= ns_to_cyc(`CBFG_BLANK_T1_NS);
				2'b10: blank_len_r <= ns_to_cyc(`CBFG_BLANK_T2_NS);
				default: blank_len_r <= ns_to_cyc(`CBFG_BLANK_T3_NS);
			endcase
		end
	end

	// One blank timer per bridge.
	cbfg_blank_timer #(.CW(BW)) u_blank_a (
		.pclk(pclk),
		.presetn(presetn),
		.sw_event(sw_event[0]),
		.length(blank_len_r),
		.blank(blank[0])
	);
	cbfg_blank_timer #(.CW(BW)) u_blank_b (
		.pclk(pclk),
		.presetn(presetn),
		.sw_event(sw_event[1]),
		.length(blank_len_r),
		.blank(blank[1])
	);

	assign hs_blank = blank[0] | blank[1];

	// ------------------------------------------------------------
	// Flag clearing
	// ------------------------------------------------------------
	// Track disable input and the last command words.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dis_d_r <= 1'b0;
		end else begin
			dis_d_r <= driver_disable_input;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_a_r <= '0;
			last_b_r <= '0;
		end else if (cmd_valid) begin
			last_a_r <= coil_a_word;
			last_b_r <= coil_b_word;
		end
	end

	// Clear on re-enable (falling disable), zero command or software.
	assign clear = (dis_d_r && !driver_disable_input) || sw_clear_r ||
		(cmd_valid && coil_a_word == `CBFG_ZERO_CURRENT &&
		coil_b_word == `CBFG_ZERO_CURRENT);

	// ------------------------------------------------------------
	// Fault counters
	// ------------------------------------------------------------
	// Qualified events ignore the bridge's own blanking.
	assign fa.oc_event = ls_over[0] & ~blank[0] & ~fa.off;
	assign fb.oc_event = ls_over[1] & ~blank[1] & ~fb.off;
	assign fh.oc_event = hs_over & ~hs_blank & ~fh.off;
	assign fa.cycle_start = cycle_start;
	assign fb.cycle_start = cycle_start;
	assign fh.cycle_start = cycle_start;
	assign fa.clear = clear;
	assign fb.clear = clear;
	assign fh.clear = clear;

	// Separate counters for each low side and the high side.
	cbfg_fault_counter u_cnt_a (.pclk(pclk), .presetn(presetn), .br(fa));
	cbfg_fault_counter u_cnt_b (.pclk(pclk), .presetn(presetn), .br(fb));
	cbfg_fault_counter u_cnt_h (.pclk(pclk), .presetn(presetn), .br(fh));

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Bridges are off for own faults, high-side faults, heat or disable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bridge_off <= 2'b11;
		end else begin
			bridge_off[0] <= fa.off | fa.oc_event | fh.off | fh.oc_event |
				overtemp | driver_disable_input;
			bridge_off[1] <= fb.off | fb.oc_event | fh.off | fh.oc_event |
				overtemp | driver_disable_input;
		end
	end

	// Flags follow the counters; overtemperature is live.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_flags <= '0;
			overtemp_flag <= 1'b0;
		end else begin
			err_flags <= {fh.flag, fb.flag, fa.flag};
			overtemp_flag <= overtemp;
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Zero-wait slave; pready high in every access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	// Write to control clear bit issues a clear pulse.
	// The write lands only at the access edge, where pready is seen high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_clear_r <= 1'b0;
		end else begin
			sw_clear_r <= psel && penable && pready && pwrite &&
				paddr == `CBFG_ADDR_CTRL && pwdata[`CBFG_CTRL_CLR_BIT];
		end
	end

	// Read data and error answer are registered in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata <= '0;
			case (paddr)
				`CBFG_ADDR_CTRL: prdata <= `CBFG_CTRL_RESET;
				`CBFG_ADDR_STATUS: prdata <= {24'h00_0000, blank_select_high,
					blank_select_low, overtemp, fh.flag, fb.flag, fa.flag,
					bridge_off};
				`CBFG_ADDR_CNT: prdata <= {26'h000_0000, fh.count, fb.count, fa.count};
				`CBFG_ADDR_COIL: prdata <= {24'h00_0000, last_b_r, last_a_r};
				default: pslverr <= 1'b1;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- sim/cbfg_guard_asserts.sv ----
// Concurrent checks on the guard top-level ports.
`timescale 1ns/1ps
`default_nettype none
module cbfg_guard_asserts (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pready, // APB ready.
	input wire logic driver_disable_input, // Driver disable.
	input wire logic [1:0] sw_event, // Switching events.
	input wire logic [1:0] ls_over, // Low-side over limit.
	input wire logic hs_over, // High-side over limit.
	input wire logic overtemp, // Overtemperature.
	input wire logic cmd_valid, // Command pulse.
	input wire logic [3:0] coil_a_word, // Coil A word.
	input wire logic [3:0] coil_b_word, // Coil B word.
	input wire logic [1:0] bridge_off, // Bridges off.
	input wire logic [2:0] err_flags, // Error flags.
	input wire logic overtemp_flag // Overtemperature flag.
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [8:0] since_a_r; // Cycles since bridge A switched.
	logic [8:0] since_b_r; // Cycles since bridge B switched.
	logic quiet_a; // Bridge A surely past its longest blank.
	logic quiet_b; // Bridge B surely past its longest blank.
	logic cause_a; // Anything that may switch bridge A off.
	// Saturating counters, so the longest blank is known to be over.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_a_r <= 9'h000;
			since_b_r <= 9'h000;
		end else begin
			since_a_r <= sw_event[0] ? 9'h000 : since_a_r + {8'h00, since_a_r != 9'h1ff};
			since_b_r <= sw_event[1] ? 9'h000 : since_b_r + {8'h00, since_b_r != 9'h1ff};
		end
	end
	assign quiet_a = since_a_r > 9'h12d && !sw_event[0];
	assign quiet_b = since_b_r > 9'h12d && !sw_event[1];
	assign cause_a = ls_over[0] || hs_over || overtemp || driver_disable_input;
	property p_setup;
		psel && !penable |=> pready;
	endproperty
	a_setup: assert property (p_setup) else $error("No ready after setup cycle.");
	property p_ls;
		quiet_a && ls_over[0] && !bridge_off[0] |-> ##[1:2] bridge_off[0];
	endproperty
	a_ls: assert property (p_ls) else $error("Low-side fault missed.");
	property p_blank;
		sw_event[0] && ls_over[0] && !bridge_off[0] && !hs_over && !overtemp
			&& !driver_disable_input |=> !bridge_off[0] [*2];
	endproperty
	a_blank: assert property (p_blank) else $error("Fault taken in blank.");
	property p_hs;
		hs_over && quiet_a && quiet_b |-> ##[1:2] bridge_off == 2'b11;
	endproperty
	a_hs: assert property (p_hs) else $error("High-side fault missed.");
	property p_ot;
		overtemp |-> ##[1:2] bridge_off == 2'b11;
	endproperty
	a_ot: assert property (p_ot) else $error("Overtemperature not off.");
	property p_otf;
		overtemp [*2] |-> overtemp_flag;
	endproperty
	a_otf: assert property (p_otf) else $error("Overtemperature flag low.");
	property p_dis;
		driver_disable_input |-> ##[1:2] bridge_off == 2'b11;
	endproperty
	a_dis: assert property (p_dis) else $error("Disable not honoured.");
	property p_lock;
		$rose(err_flags[0]) |-> bridge_off[0];
	endproperty
	a_lock: assert property (p_lock) else $error("Flag without lock.");
	property p_cause;
		$rose(bridge_off[0]) |-> $past(cause_a) || $past(cause_a, 2);
	endproperty
	a_cause: assert property (p_cause) else $error("Bridge off without cause.");
	property p_clr;
		(cmd_valid && coil_a_word == 4'h0 && coil_b_word == 4'h0) || $fell(driver_disable_input)
			|-> ##[1:2] err_flags == 3'b000;
	endproperty
	a_clr: assert property (p_clr) else $error("Flags not cleared.");
endmodule
`default_nettype wire

// ---- sim/cbfg_bridge_model.sv ----
// Chopper oscillator and bridges: cycle start, then switching events.
`timescale 1ns/1ps
`default_nettype none
module cbfg_bridge_model #(
	parameter int PERIOD = 400 // PWM period in clocks.
) (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset, active low.
	output logic cycle_start, // Cycle start pulse.
	output logic [1:0] sw_event // Bridges switch one clock later.
);
	logic [9:0] tick_r; // Position in the PWM period.
	// Both bridges switch on right after each cycle start.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_r <= 10'h000;
			cycle_start <= 1'b0;
			sw_event <= 2'b00;
		end else begin
			tick_r <= (tick_r == 10'(PERIOD - 1)) ? 10'h000 : tick_r + 10'h001;
			cycle_start <= tick_r == 10'h000;
			sw_event <= {2{cycle_start}};
		end
	end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the guard top.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, lo = 1'b0, hi = 1'b1, dis = 1'b0, cs, ot = 1'b0, cv = 1'b0;
	logic [1:0] sw, off, strap [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
	logic [2:0] fv = 3'b000, flags; // Faults {high side, B, A}.
	logic [3:0] wa = 4'h0, wb = 4'h0;
	logic otf;
	int blen [4] = '{600 / 5, 900 / 5, 1200 / 5, 1500 / 5};
	int n_mismatch = 0, check_count = 0;
	always #2.5 pclk = ~pclk;
	cbfg_guard dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .blank_select_low(lo), .blank_select_high(hi),
		.driver_disable_input(dis), .cycle_start(cs), .sw_event(sw), .ls_over(fv[1:0]),
		.hs_over(fv[2]), .overtemp(ot), .cmd_valid(cv), .coil_a_word(wa), .coil_b_word(wb),
		.bridge_off(off), .err_flags(flags), .overtemp_flag(otf));
	cbfg_bridge_model model_u (.pclk(pclk), .presetn(presetn), .cycle_start(cs), .sw_event(sw));
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer, begun just after an edge; waits for pready.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk); penable <= 1'b1;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		q = pslverr ? 32'hdead_beef : prdata;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
		if (n >= 50) begin n_mismatch++; report_and_stop(); end
	endtask
	task automatic wcs(input int k);
		int n;
		repeat (k) begin
			n = 0;
			do begin @(posedge pclk); n++; end while (cs !== 1'b1 && n < 1000);
			if (n >= 1000) begin n_mismatch++; report_and_stop(); end
		end
	endtask
	// Fault pulse inside the blank, then one sampled dly clocks after switching.
	task automatic hit(input logic [2:0] m, input int dly);
		wcs(1); fv <= m;
		@(posedge pclk); fv <= 3'b000;
		repeat (dly - 1) @(posedge pclk);
		fv <= m;
		@(posedge pclk); fv <= 3'b000;
	endtask
	task automatic cmd(input logic [3:0] a, input logic [3:0] b);
		cv <= 1'b1; wa <= a; wb <= b;
		@(posedge pclk); cv <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	initial begin repeat (90000) @(posedge pclk); n_mismatch++; report_and_stop(); end
	// Registered outputs are read right after an edge, before that edge updates them.
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h004, 0);
		chk(q, 32'h0000_0080);
		apb(0, 12'h010, 0);
		chk(q, 32'hdead_beef);
		for (int i = 0; i < 4; i++) begin
			{hi, lo} <= strap[i];
			hit(3'b011, blen[i] - 1);
			repeat (2) @(posedge pclk);
			chk(off, 2'b00);
			hit(3'b011, blen[i] + 1);
			repeat (2) @(posedge pclk);
			chk(off, 2'b11);
			apb(0, 12'h008, 0);
			chk(q, 32'h0000_0005);
			apb(1, 12'h000, 32'h0000_0001);
		end
		{hi, lo} <= 2'b10;
		// Late faults lie well past the longest blank, so the checker sees them too.
		hit(3'b100, 350);
		repeat (2) @(posedge pclk);
		chk(off, 2'b11);
		apb(0, 12'h008, 0);
		chk(q, 32'h0000_0010);
		// A new cycle first ends the high-side off, so only the disable holds the bridges.
		wcs(1);
		dis <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(off, 2'b11);
		dis <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(flags, 3'b000);
		apb(0, 12'h008, 0);
		chk(q, 32'h0000_0000);
		ot <= 1'b1;
		cmd(4'h2, 4'h2);
		chk({otf, off}, 3'b111);
		apb(0, 12'h00c, 0);
		chk(q, 32'h0000_0022);
		ot <= 1'b0;
		wcs(1);
		repeat (3) @(posedge pclk);
		chk({otf, off}, 3'b000);
		repeat (3) hit(3'b001, 350);
		repeat (2) @(posedge pclk);
		chk(flags, 3'b001);
		cmd(4'h7 + 4'h1, 4'h7 + 4'h1);
		chk(flags, 3'b001);
		apb(0, 12'h00c, 0);
		chk(q, 32'h0000_0088);
		wcs(62);
		repeat (3) @(posedge pclk);
		chk(off, 2'b01);
		cmd(4'h0, 4'h0);
		chk(flags, 3'b000);
		wcs(1);
		repeat (3) @(posedge pclk);
		chk(off, 2'b00);
		hit(3'b001, 241);
		wcs(62);
		apb(0, 12'h008, 0);
		chk(q, 32'h0000_0001);
		wcs(3);
		apb(0, 12'h008, 0);
		chk(q, 32'h0000_0000);
		// Reset in mid-run while bridge A is off and its counter holds one event.
		hit(3'b001, 241);
		presetn <= 1'b0;
		@(posedge pclk);
		chk({flags, otf, off}, 6'h03);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(off, 2'b00);
		apb(0, 12'h008, 0);
		chk(q, 32'h0000_0000);
		report_and_stop();
	end
endmodule
bind cbfg_guard cbfg_guard_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .driver_disable_input(driver_disable_input),
	.sw_event(sw_event), .ls_over(ls_over), .hs_over(hs_over), .overtemp(overtemp),
	.cmd_valid(cmd_valid), .coil_a_word(coil_a_word), .coil_b_word(coil_b_word),
	.bridge_off(bridge_off), .err_flags(err_flags), .overtemp_flag(overtemp_flag));
`default_nettype wire
